// >>> hw/two_wire_pkg.sv
// shared constants for the two-wire sensor command port and its host
package two_wire_pkg;
	// command word layout, msb first: address then code
	localparam int        ADDR_W        = 3;
	localparam int        CODE_W        = 5;
	localparam logic [2:0] DEV_ADDR     = 3'h0;
	localparam logic [4:0] CMD_MEAS_T   = 5'h03;
	localparam logic [4:0] CMD_MEAS_RH  = 5'h05;
	localparam logic [4:0] CMD_STAT_RD  = 5'h07;
	localparam logic [4:0] CMD_STAT_WR  = 5'h06;
	localparam logic [4:0] CMD_SOFT_RST = 5'h1e;

	// bit slots inside one nine-clock frame
	localparam logic [3:0] LAST_BIT     = 4'h7;
	localparam logic [3:0] ACK_SLOT     = 4'h8;
	localparam logic [3:0] CONN_HIGHS   = 4'h9;

	// status register
	localparam int        STAT_W        = 3;
	localparam logic [2:0] STAT_RESET   = 3'h0;
	localparam int        STAT_EOB_BIT  = 6;

	// measurement word, right justified in two bytes
	localparam int        MEAS_W        = 14;
	localparam int        WORD_W        = 16;

	// timing
	localparam int        MCLK_MHZ      = 250;
	localparam int        SCK_HALF_NS   = 200;
	localparam int        T_BOOT_US     = 11000;
	localparam int        T_SOFT_RST_US = 11000;
	localparam int        SCK_HALF_CYC  = (SCK_HALF_NS * MCLK_MHZ + 999) / 1000;
	localparam int        BOOT_CYC      = T_BOOT_US * MCLK_MHZ;
	localparam int        SOFT_RST_CYC  = T_SOFT_RST_US * MCLK_MHZ;
	localparam int        WAIT_W        = 24;
	localparam int        DIV_W         = 8;
endpackage

// >>> hw/sensor_link_if.sv
// two-wire link: host-driven shift clock and open-drain data line
`timescale 1ns/1ns
interface sensor_link_if;
	logic sck;
	logic host_oe;
	logic dev_oe;
	logic data;

	// pull-up holds the line high unless either end pulls it low
	assign data = ~(host_oe | dev_oe);

	modport host (output sck, output host_oe, input data);
	modport dev  (input sck, input data, output dev_oe);
endinterface

// >>> hw/sensor_cmd_port.sv
// sensor-side command port: link logic on the shift clock, user side on mclk
`timescale 1ns/1ns
module sensor_cmd_port #(
	parameter int MEAS_W = two_wire_pkg::MEAS_W
) (
	input  wire logic              rst_i,
	input  wire logic              mclk_i,
	sensor_link_if.dev             lnk,
	input  wire logic              meas_done_i,
	input  wire logic [MEAS_W-1:0] meas_data_i,
	input  wire logic              low_batt_i,
	output logic                   meas_req_o,
	output logic                   meas_hum_o,
	output logic [2:0]             status_o
);
	if (MEAS_W < 1 || MEAS_W > two_wire_pkg::WORD_W - 1) begin
		$error("MEAS_W must leave the top word bit zero");
	end

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_CMD   = 3'h1,
		S_CACK  = 3'h3,
		S_WSTAT = 3'h2,
		S_WACK  = 3'h6,
		S_MWAIT = 3'h7,
		S_SEND  = 3'h5
	} dev_state_e;

	// link side, clocked by falling shift clock
	typedef struct packed {
		dev_state_e st;
		logic [3:0] cnt;
		logic [15:0] sh;
		logic       last;
		logic       drv;
		logic [2:0] stat;
		logic [3:0] ones;
		logic       req_tog;
		logic       rd_tog;
		logic       hum;
	} link_s;

	// user side, clocked by mclk
	typedef struct packed {
		logic [2:0]        req_sync;
		logic [2:0]        rd_sync;
		logic              req_p;
		logic              hum;
		logic              ready;
		logic [MEAS_W-1:0] word;
		logic              eob;
		logic [2:0]        st1;
		logic [2:0]        st2;
		logic [2:0]        st3;
		logic [2:0]        st_out;
	} sys_s;

	link_s link_reg;
	link_s link_next;
	sys_s  sys_reg;
	sys_s  sys_next;
	logic  rise_reg;
	logic [7:0]  cmd8;
	logic [4:0]  code;
	logic        cmd_ok;
	logic [15:0] word16;
	logic [7:0]  stat_byte;

	assign cmd8      = {link_reg.sh[6:0], rise_reg};
	assign code      = cmd8[4:0];
	assign word16    = 16'(sys_reg.word);
	assign stat_byte = 8'(link_reg.stat) | (8'(sys_reg.eob) << two_wire_pkg::STAT_EOB_BIT);

	// address must be zero and the code a known one
	always_comb begin
		cmd_ok = 1'b0;
		if (cmd8[7:5] == two_wire_pkg::DEV_ADDR) begin
			unique case (code)
				two_wire_pkg::CMD_MEAS_T, two_wire_pkg::CMD_MEAS_RH,
				two_wire_pkg::CMD_STAT_RD, two_wire_pkg::CMD_STAT_WR,
				two_wire_pkg::CMD_SOFT_RST: cmd_ok = 1'b1;
				default: cmd_ok = 1'b0;
			endcase
		end
	end

	// host data is stable while the clock is high
	always_ff @(posedge lnk.sck or posedge rst_i) begin
		if (rst_i) begin
			rise_reg <= 1'b1;
		end else begin
			rise_reg <= lnk.data;
		end
	end

	always_comb begin
		link_next = link_reg;
		link_next.ones = rise_reg ? ((link_reg.ones == two_wire_pkg::CONN_HIGHS - 4'h1) ?
			link_reg.ones : link_reg.ones + 4'h1) : 4'h0;
		unique case (link_reg.st)
			S_IDLE: begin
				link_next.drv = 1'b0;
				// low at the rise, high at the fall: data rose while clock high
				if (!rise_reg && lnk.data) begin
					link_next.st  = S_CMD;
					link_next.cnt = 4'h0;
				end
			end
			S_CMD: begin
				link_next.sh  = {link_reg.sh[14:0], rise_reg};
				link_next.cnt = link_reg.cnt + 4'h1;
				if (link_reg.cnt == two_wire_pkg::LAST_BIT) begin
					link_next.st  = cmd_ok ? S_CACK : S_IDLE;
					link_next.drv = cmd_ok;
				end
			end
			S_CACK: begin
				link_next.drv = 1'b0;
				link_next.st  = S_IDLE;
				unique case (link_reg.sh[4:0])
					two_wire_pkg::CMD_MEAS_T, two_wire_pkg::CMD_MEAS_RH: begin
						link_next.st      = S_MWAIT;
						link_next.req_tog = ~link_reg.req_tog;
						link_next.hum     = (link_reg.sh[4:0] == two_wire_pkg::CMD_MEAS_RH);
					end
					two_wire_pkg::CMD_STAT_RD: begin
						link_next.st   = S_SEND;
						link_next.sh   = {stat_byte, 8'h00};
						link_next.drv  = ~stat_byte[7];
						link_next.cnt  = 4'h0;
						link_next.last = 1'b1;
					end
					two_wire_pkg::CMD_STAT_WR: begin
						link_next.st  = S_WSTAT;
						link_next.cnt = 4'h0;
					end
					two_wire_pkg::CMD_SOFT_RST: begin
						link_next.stat = two_wire_pkg::STAT_RESET;
					end
					default: link_next.st = S_IDLE;
				endcase
			end
			S_WSTAT: begin
				link_next.sh  = {link_reg.sh[14:0], rise_reg};
				link_next.cnt = link_reg.cnt + 4'h1;
				if (link_reg.cnt == two_wire_pkg::LAST_BIT) begin
					link_next.stat = cmd8[two_wire_pkg::STAT_W-1:0];
					link_next.st   = S_WACK;
					link_next.drv  = 1'b1;
				end
			end
			S_WACK: begin
				link_next.drv = 1'b0;
				link_next.st  = S_IDLE;
			end
			S_MWAIT: begin
				// top word bit is zero, so the ready level doubles as the msb
				if (sys_reg.ready) begin
					link_next.st     = S_SEND;
					link_next.sh     = {word16[14:0], 1'b0};
					link_next.drv    = ~word16[14];
					link_next.cnt    = 4'h1;
					link_next.last   = 1'b0;
					link_next.rd_tog = ~link_reg.rd_tog;
				end
			end
			S_SEND: begin
				if (link_reg.cnt == two_wire_pkg::LAST_BIT) begin
					link_next.drv = 1'b0;
					link_next.cnt = two_wire_pkg::ACK_SLOT;
				end else if (link_reg.cnt == two_wire_pkg::ACK_SLOT) begin
					if (link_reg.last) begin
						link_next.st = S_IDLE;
					end else begin
						link_next.sh   = {link_reg.sh[14:0], 1'b0};
						link_next.drv  = ~link_reg.sh[14];
						link_next.cnt  = 4'h0;
						link_next.last = 1'b1;
					end
				end else begin
					link_next.sh  = {link_reg.sh[14:0], 1'b0};
					link_next.drv = ~link_reg.sh[14];
					link_next.cnt = link_reg.cnt + 4'h1;
				end
			end
			default: begin
				link_next.st  = S_IDLE;
				link_next.drv = 1'b0;
			end
		endcase
		// ninth consecutive high clock: interface only, status kept
		if (rise_reg && link_reg.ones == two_wire_pkg::CONN_HIGHS - 4'h1) begin
			link_next.st  = S_IDLE;
			link_next.drv = 1'b0;
			link_next.cnt = 4'h0;
		end
	end

	// state holds indefinitely between clock edges
	always_ff @(negedge lnk.sck or posedge rst_i) begin
		if (rst_i) begin
			link_reg      <= '0;
			link_reg.st   <= S_IDLE;
			link_reg.stat <= two_wire_pkg::STAT_RESET;
		end else begin
			link_reg <= link_next;
		end
	end

	// ready pull-low needs no clock edge, the link clock is stopped then
	assign lnk.dev_oe = link_reg.drv | ((link_reg.st == S_MWAIT) & sys_reg.ready);

	always_comb begin
		sys_next          = sys_reg;
		sys_next.req_sync = {sys_reg.req_sync[1:0], link_reg.req_tog};
		sys_next.rd_sync  = {sys_reg.rd_sync[1:0], link_reg.rd_tog};
		sys_next.st1      = link_reg.stat;
		sys_next.st2      = sys_reg.st1;
		sys_next.st3      = sys_reg.st2;
		// status bits may settle a cycle apart, pass only a steady word
		if (sys_reg.st2 == sys_reg.st3) begin
			sys_next.st_out = sys_reg.st3;
		end
		sys_next.req_p    = sys_reg.req_sync[2] ^ sys_reg.req_sync[1];
		if (sys_reg.req_sync[2] ^ sys_reg.req_sync[1]) begin
			sys_next.hum = link_reg.hum;
		end
		// a new result wins over the clear from the readout
		if (meas_done_i) begin
			sys_next.ready = 1'b1;
			sys_next.word  = meas_data_i;
			sys_next.eob   = low_batt_i;
		end else if (sys_reg.rd_sync[2] ^ sys_reg.rd_sync[1]) begin
			sys_next.ready = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sys_reg <= '0;
		end else begin
			sys_reg <= sys_next;
		end
	end

	assign meas_req_o = sys_reg.req_p;
	assign meas_hum_o = sys_reg.hum;
	assign status_o   = sys_reg.st_out;
endmodule

// >>> hw/sensor_cmd_host.sv
// host end: makes the shift clock from mclk and runs command frames
`timescale 1ns/1ns
module sensor_cmd_host #(
	parameter int SCK_HALF = two_wire_pkg::SCK_HALF_CYC,
	parameter int BOOT_CYC = two_wire_pkg::BOOT_CYC,
	parameter int RST_CYC  = two_wire_pkg::SOFT_RST_CYC
) (
	input  wire logic        rst_i,
	input  wire logic        mclk_i,
	sensor_link_if.host      lnk,
	input  wire logic        cmd_valid_i,
	input  wire logic [4:0]  cmd_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        conn_rst_i,
	output logic             cmd_ready_o,
	output logic             done_o,
	output logic             nack_o,
	output logic [15:0]      rdata_o
);
	localparam int WW = two_wire_pkg::WAIT_W;
	localparam int DW = two_wire_pkg::DIV_W;

	if (SCK_HALF < 2 || SCK_HALF >= 2 ** DW) begin
		$error("SCK_HALF out of range");
	end
	if (BOOT_CYC < 1 || BOOT_CYC >= 2 ** WW || RST_CYC < 1 || RST_CYC >= 2 ** WW) begin
		$error("wait counts out of range");
	end

	typedef enum logic [2:0] {
		H_PWR   = 3'h0,
		H_IDLE  = 3'h1,
		H_START = 3'h3,
		H_XFER  = 3'h2,
		H_WRDY  = 3'h6,
		H_RSTW  = 3'h7,
		H_CONN  = 3'h5
	} host_state_e;

	typedef enum logic [1:0] {
		F_CMD = 2'h0,
		F_WR  = 2'h1,
		F_RD  = 2'h3
	} frame_e;

	typedef struct packed {
		host_state_e st;
		frame_e      fr;
		logic [DW-1:0] div;
		logic        sck;
		logic        oe;
		logic [4:0]  cnt;
		logic        last;
		logic [7:0]  sh;
		logic [4:0]  cmd;
		logic [7:0]  wdata;
		logic [15:0] rdata;
		logic        done;
		logic        nack;
		logic [WW-1:0] wt;
		logic        d_s1;
		logic        d_s2;
	} host_s;

	host_s h_reg;
	host_s h_next;
	logic  tick;
	logic  din;

	assign tick = (h_reg.div == DW'(SCK_HALF - 1));
	assign din  = h_reg.d_s2;

	always_comb begin
		h_next      = h_reg;
		h_next.d_s1 = lnk.data;
		h_next.d_s2 = h_reg.d_s1;
		h_next.div  = tick ? '0 : h_reg.div + 1'b1;
		h_next.done = 1'b0;
		unique case (h_reg.st)
			H_PWR: begin
				h_next.wt = h_reg.wt + 1'b1;
				if (h_reg.wt == WW'(BOOT_CYC - 1)) begin
					h_next.st = H_IDLE;
				end
			end
			H_IDLE: begin
				h_next.sck = 1'b0;
				h_next.oe  = 1'b0;
				h_next.cnt = '0;
				if (conn_rst_i) begin
					h_next.st = H_CONN;
				end else if (cmd_valid_i) begin
					h_next.st    = H_START;
					h_next.sh    = {two_wire_pkg::DEV_ADDR, cmd_i};
					h_next.cmd   = cmd_i;
					h_next.wdata = wdata_i;
					h_next.nack  = 1'b0;
				end
			end
			H_START: begin
				if (tick) begin
					h_next.cnt = h_reg.cnt + 5'h1;
					unique case (h_reg.cnt)
						5'h0: h_next.sck = 1'b1;
						5'h1: h_next.oe  = 1'b1;
						5'h2: h_next.sck = 1'b0;
						5'h3: h_next.sck = 1'b1;
						5'h4: h_next.oe  = 1'b0;
						default: begin
							h_next.sck = 1'b0;
							h_next.st  = H_XFER;
							h_next.fr  = F_CMD;
							h_next.cnt = '0;
						end
					endcase
				end
			end
			H_XFER: begin
				// data changes one cycle after the fall, never near the rise
				if (!h_reg.sck && h_reg.div == '0) begin
					if (h_reg.cnt < 5'(two_wire_pkg::ACK_SLOT)) begin
						h_next.oe = (h_reg.fr != F_RD) & ~h_reg.sh[7];
					end else begin
						h_next.oe = (h_reg.fr == F_RD) & ~h_reg.last;
					end
				end
				if (tick && !h_reg.sck) begin
					h_next.sck = 1'b1;
				end else if (tick) begin
					h_next.sck = 1'b0;
					h_next.cnt = h_reg.cnt + 5'h1;
					if (h_reg.cnt < 5'(two_wire_pkg::ACK_SLOT)) begin
						h_next.sh = {h_reg.sh[6:0], din};
					end else begin
						h_next.cnt = '0;
						h_next.st  = H_IDLE;
						h_next.done = 1'b1;
						unique case (h_reg.fr)
							F_CMD: begin
								h_next.nack = din;
								if (!din) begin
									unique case (h_reg.cmd)
										two_wire_pkg::CMD_MEAS_T, two_wire_pkg::CMD_MEAS_RH: begin
											h_next.st   = H_WRDY;
											h_next.done = 1'b0;
										end
										two_wire_pkg::CMD_STAT_RD: begin
											h_next.st   = H_XFER;
											h_next.fr   = F_RD;
											h_next.last = 1'b1;
											h_next.done = 1'b0;
										end
										two_wire_pkg::CMD_STAT_WR: begin
											h_next.st   = H_XFER;
											h_next.fr   = F_WR;
											h_next.sh   = h_reg.wdata;
											h_next.done = 1'b0;
										end
										two_wire_pkg::CMD_SOFT_RST: begin
											h_next.st   = H_RSTW;
											h_next.wt   = '0;
											h_next.done = 1'b0;
										end
										default: h_next.st = H_IDLE;
									endcase
								end
							end
							F_WR: h_next.nack = din;
							default: begin
								h_next.rdata = {h_reg.rdata[7:0], h_reg.sh};
								if (!h_reg.last) begin
									h_next.st   = H_XFER;
									h_next.last = 1'b1;
									h_next.done = 1'b0;
								end
							end
						endcase
					end
				end
			end
			H_WRDY: begin
				h_next.oe  = 1'b0;
				h_next.sck = 1'b0;
				// one half period of guard lets the released ack settle
				if (tick) begin
					if (h_reg.cnt == '0) begin
						h_next.cnt = 5'h1;
					end else if (!din) begin
						h_next.st   = H_XFER;
						h_next.fr   = F_RD;
						h_next.last = 1'b0;
						h_next.cnt  = '0;
					end
				end
			end
			H_RSTW: begin
				h_next.wt = h_reg.wt + 1'b1;
				if (h_reg.wt == WW'(RST_CYC - 1)) begin
					h_next.st   = H_IDLE;
					h_next.done = 1'b1;
				end
			end
			H_CONN: begin
				h_next.oe = 1'b0;
				if (tick) begin
					h_next.sck = ~h_reg.sck;
					h_next.cnt = h_reg.cnt + 5'h1;
					if (h_reg.cnt == 5'(2 * two_wire_pkg::CONN_HIGHS - 1)) begin
						h_next.st   = H_IDLE;
						h_next.sck  = 1'b0;
						h_next.done = 1'b1;
					end
				end
			end
			default: h_next.st = H_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			h_reg      <= '0;
			h_reg.st   <= H_PWR;
			h_reg.d_s1 <= 1'b1;
			h_reg.d_s2 <= 1'b1;
		end else begin
			h_reg <= h_next;
		end
	end

	// i2c on the same wires must be finished before a frame starts
	assign lnk.sck     = h_reg.sck;
	assign lnk.host_oe = h_reg.oe;
	assign cmd_ready_o = (h_reg.st == H_IDLE);
	assign done_o      = h_reg.done;
	assign nack_o      = h_reg.nack;
	assign rdata_o     = h_reg.rdata;
endmodule

// >>> test/sensor_link_sva.sv
// link checker for the two-wire command port and its host
`timescale 1ns/1ns
module sensor_link_sva #(
	parameter int BOOT_CYC = 200,
	parameter int RST_CYC  = 200
) (
	input  wire logic rst_i,
	input  wire logic mclk_i,
	input  wire logic sck,
	input  wire logic host_oe,
	input  wire logic dev_oe,
	input  wire logic data
);
	logic       sck_q;
	logic       data_q;
	logic       wait_rdy;
	logic [5:0] cnt;
	logic [7:0] word;
	int         idle_cnt;
	int         need;
	logic       fall;
	logic       rise;
	logic       cmd_ok;

	assign fall   = sck_q & ~sck;
	assign rise   = ~sck_q & sck;
	assign cmd_ok = (word[7:5] == two_wire_pkg::DEV_ADDR) && (word[4:0] inside {two_wire_pkg::CMD_MEAS_T,
		two_wire_pkg::CMD_MEAS_RH, two_wire_pkg::CMD_STAT_RD, two_wire_pkg::CMD_STAT_WR, two_wire_pkg::CMD_SOFT_RST});

	// cnt: sck falls since the data rise that closes a start sequence
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sck_q    <= 1'b0;
			data_q   <= 1'b1;
			cnt      <= 6'h3f;
			word     <= 8'h00;
			idle_cnt <= 0;
			need     <= BOOT_CYC;
			wait_rdy <= 1'b0;
		end else begin
			sck_q  <= sck;
			data_q <= data;
			if (sck && sck_q && data && !data_q) begin
				cnt <= 6'h00;
			end else if (fall && cnt != 6'h3f) begin
				cnt <= cnt + 6'h01;
			end
			if (rise && cnt >= 6'h01 && cnt <= 6'h08) begin
				word <= {word[6:0], data};
			end
			if (fall && cnt == 6'h09 && cmd_ok && word[4:0] == two_wire_pkg::CMD_SOFT_RST) begin
				idle_cnt <= 0;
				need     <= RST_CYC;
			end else if (idle_cnt < need) begin
				idle_cnt <= idle_cnt + 1;
			end
			if (fall && cnt == 6'h09 && cmd_ok && word[4:0] inside {two_wire_pkg::CMD_MEAS_T,
				two_wire_pkg::CMD_MEAS_RH}) begin
				wait_rdy <= 1'b1;
			end else if (dev_oe) begin
				wait_rdy <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	AST_ACK_DRIVE: assert property (fall && cnt == 6'h08 && cmd_ok |-> ##[0:2] dev_oe ##1 dev_oe [*6])
		else $error("ack missing after eighth clock");
	AST_ACK_RELEASE: assert property (fall && cnt == 6'h09 && cmd_ok && word[4:0] != two_wire_pkg::CMD_STAT_RD
		|-> ##[0:2] !dev_oe)
		else $error("ack not released after ninth clock");
	AST_NO_ACK: assert property (fall && cnt == 6'h08 && !cmd_ok |-> (!dev_oe) [*8])
		else $error("reserved command acknowledged");
	AST_ADDR: assert property (fall && cnt == 6'h08 |-> word[7:5] == two_wire_pkg::DEV_ADDR)
		else $error("command word address not zero");
	AST_HOST_HOLD: assert property (rise |-> ##1 $stable(host_oe) [*6])
		else $error("host data changed while clock high");
	AST_DEV_CHANGE: assert property ($changed(dev_oe) |-> !sck)
		else $error("device data changed while clock high");
	AST_QUIET: assert property (rise |-> idle_cnt >= need)
		else $error("clock started before wait interval");
	AST_READY_WAIT: assert property (wait_rdy |-> !rise)
		else $error("clock restarted before data ready");
	AST_OPEN_DRAIN: assert property (fall && cnt == 6'h08 |-> ##[1:2] (!host_oe) [*6])
		else $error("host still pulling data in the acknowledge slot");
endmodule

// >>> test/tb_sensor_two_wire_command_port.sv
// self-checking bench: host and sensor port joined over the link
`timescale 1ns/1ns
module tb_sensor_two_wire_command_port;
	logic        rst_i       = 1'b0;
	logic        mclk_i      = 1'b0;
	logic        cmd_valid_i = 1'b0;
	logic [4:0]  cmd_i       = 5'h00;
	logic [7:0]  wdata_i     = 8'h00;
	logic        conn_rst_i  = 1'b0;
	logic        meas_done_i = 1'b0;
	logic [13:0] meas_data_i = 14'h0000;
	logic        low_batt_i  = 1'b1;
	logic        cmd_ready_o;
	logic        done_o;
	logic        nack_o;
	logic [15:0] rdata_o;
	logic        meas_req_o;
	logic        meas_hum_o;
	logic [2:0]  status_o;
	logic        hum_seen;
	int          n_errors = 0;
	int          compares = 0;
	logic [4:0]  rsv [3]  = '{5'h01, 5'h0a, 5'h1c};

	always #2 mclk_i = ~mclk_i;

	sensor_link_if lnk ();

	sensor_cmd_host #(.SCK_HALF(8), .BOOT_CYC(200), .RST_CYC(200)) sensor_cmd_host_i (
		.rst_i(rst_i), .mclk_i(mclk_i), .lnk(lnk), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.wdata_i(wdata_i), .conn_rst_i(conn_rst_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
		.nack_o(nack_o), .rdata_o(rdata_o));

	sensor_cmd_port sensor_cmd_port_i (
		.rst_i(rst_i), .mclk_i(mclk_i), .lnk(lnk), .meas_done_i(meas_done_i), .meas_data_i(meas_data_i),
		.low_batt_i(low_batt_i), .meas_req_o(meas_req_o), .meas_hum_o(meas_hum_o), .status_o(status_o));

	sensor_link_sva #(.BOOT_CYC(200), .RST_CYC(200)) sensor_link_sva_i (
		.rst_i(rst_i), .mclk_i(mclk_i), .sck(lnk.sck), .host_oe(lnk.host_oe), .dev_oe(lnk.dev_oe),
		.data(lnk.data));

	// sensor core stand-in: finishes a measurement some cycles after the request
	always begin
		@(negedge mclk_i iff meas_req_o === 1'b1);
		hum_seen = meas_hum_o;
		repeat (40) @(negedge mclk_i);
		meas_data_i = hum_seen ? 14'h0431 : 14'h2abc;
		meas_done_i = 1'b1;
		@(negedge mclk_i);
		meas_done_i = 1'b0;
	end

	task automatic conclude();
		if (n_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_b(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one host operation: wait idle, present request for one edge, wait done
	task automatic run(input logic [4:0] code, input logic [7:0] wd, input logic cr);
		int n;
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 5000) begin
			@(negedge mclk_i);
			n++;
		end
		if (n >= 5000) begin
			n_errors++;
			$display("MISMATCH cmd_ready_o expected 1 seen timeout");
		end
		cmd_i       = code;
		wdata_i     = wd;
		conn_rst_i  = cr;
		cmd_valid_i = ~cr;
		@(negedge mclk_i);
		cmd_valid_i = 1'b0;
		conn_rst_i  = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 20000) begin
			@(negedge mclk_i);
			n++;
		end
		if (n >= 20000) begin
			n_errors++;
			$display("MISMATCH done_o expected 1 seen timeout");
		end
		repeat (4) @(negedge mclk_i);
	endtask

	initial begin
		// a real rising edge, so every asynchronous reset process sees it
		#1;
		rst_i = 1'b1;
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		run(two_wire_pkg::CMD_STAT_RD, 8'h00, 1'b0);
		chk_w("status byte", 16'h0000, {8'h00, rdata_o[7:0]});
		chk_b("nack_o", 1'b0, nack_o);
		run(two_wire_pkg::CMD_STAT_WR, 8'hff, 1'b0);
		chk_b("nack_o", 1'b0, nack_o);
		chk_w("status_o", 16'h0007, {13'h0000, status_o});
		run(two_wire_pkg::CMD_MEAS_T, 8'h00, 1'b0);
		chk_b("meas_hum_o", 1'b0, hum_seen);
		chk_w("temp word", 16'h2abc, rdata_o);
		run(two_wire_pkg::CMD_MEAS_RH, 8'h00, 1'b0);
		chk_b("meas_hum_o", 1'b1, hum_seen);
		chk_w("humidity word", 16'h0431, rdata_o);
		run(two_wire_pkg::CMD_STAT_RD, 8'h00, 1'b0);
		chk_w("status byte", 16'h0047, {8'h00, rdata_o[7:0]});
		run(5'h00, 8'h00, 1'b1);
		run(two_wire_pkg::CMD_STAT_RD, 8'h00, 1'b0);
		chk_w("status byte", 16'h0047, {8'h00, rdata_o[7:0]});
		for (int i = 0; i < 3; i++) begin
			run(rsv[i], 8'h00, 1'b0);
			chk_b("nack_o", 1'b1, nack_o);
		end
		chk_w("status_o", 16'h0007, {13'h0000, status_o});
		run(two_wire_pkg::CMD_SOFT_RST, 8'h00, 1'b0);
		chk_b("nack_o", 1'b0, nack_o);
		run(two_wire_pkg::CMD_STAT_RD, 8'h00, 1'b0);
		chk_w("status bits", 16'h0000, {13'h0000, rdata_o[2:0]});
		chk_w("status_o", 16'h0000, {13'h0000, status_o});
		conclude();
	end

	// the full sequence needs well under a fifth of this span
	initial begin
		#200000;
		n_errors++;
		conclude();
	end
endmodule
